// ==== afe_channel_offset_gain_regs.sv ====
`timescale 1ns/100ps
module afe_channel_offset_gain_regs
   import afe_pkg::*;
#(
   parameter logic [6:0] BUS_ADDR = BUS_ADDR_DEFAULT
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic [2:0] chan_sel,
   output logic offset_sign,
   output logic [9:0] offset_mag,
   output logic [2:0] gain_code
);
   logic frame_start, frame_stop, rx_strobe, tx_req;
   logic [7:0] rx_data, tx_data;
   logic [2:0] chan_r, chan_nxt, gain_r, gain_nxt;
   logic [10:0] offset_r [NUM_CH];
   logic [10:0] offset_nxt [NUM_CH];
   logic [10:0] code_r, code_nxt;
   logic [7:0] sub_r, sub_nxt, hi_r, hi_nxt;
   logic [1:0] widx_r, widx_nxt, ridx_r, ridx_nxt;
   logic [3:0] wo_w, ws_w;

   // {hit, channel} for an offset word sub-address
   function automatic logic [3:0] off_decode(input logic [7:0] a);
      case (a)
         OFFSET_WORD_CH1: off_decode = {1'b1, CH1};
         OFFSET_WORD_CH2: off_decode = {1'b1, CH2};
         OFFSET_WORD_CH3: off_decode = {1'b1, CH3};
         OFFSET_WORD_CH4: off_decode = {1'b1, CH4};
         OFFSET_WORD_CH5: off_decode = {1'b1, CH5};
         OFFSET_WORD_CH6: off_decode = {1'b1, CH6};
         OFFSET_WORD_CH7: off_decode = {1'b1, CH7};
         OFFSET_WORD_CH8: off_decode = {1'b1, CH8};
         default: off_decode = 4'h0;
      endcase
   endfunction

   // {hit, channel} for a select command
   function automatic logic [3:0] sel_decode(input logic [7:0] a);
      case (a)
         SUB_SEL1: sel_decode = {1'b1, CH1};
         SUB_SEL2: sel_decode = {1'b1, CH2};
         SUB_SEL3: sel_decode = {1'b1, CH3};
         SUB_SEL4: sel_decode = {1'b1, CH4};
         SUB_SEL5: sel_decode = {1'b1, CH5};
         SUB_SEL6: sel_decode = {1'b1, CH6};
         SUB_SEL7: sel_decode = {1'b1, CH7};
         SUB_SEL8: sel_decode = {1'b1, CH8};
         default: sel_decode = 4'h0;
      endcase
   endfunction

   serial_byte_slave #(.BUS_ADDR(BUS_ADDR)) u_bus (
      .clk(clk),
      .rst(rst),
      .scl(scl),
      .sda_in(sda_in),
      .sda_oe(sda_oe),
      .frame_start(frame_start),
      .frame_stop(frame_stop),
      .rx_strobe(rx_strobe),
      .rx_data(rx_data),
      .tx_req(tx_req),
      .tx_data(tx_data)
   );

   assign wo_w = off_decode(sub_r);
   assign ws_w = sel_decode(rx_data);

   always_comb begin
      chan_nxt = chan_r;
      gain_nxt = gain_r;
      sub_nxt = sub_r;
      hi_nxt = hi_r;
      widx_nxt = widx_r;
      ridx_nxt = ridx_r;
      for (int i = 0; i < NUM_CH; i++) begin
         offset_nxt[i] = offset_r[i];
      end
      if (frame_start) begin
         widx_nxt = BYTE_SUB;
         ridx_nxt = BYTE_SUB;
      end else if (rx_strobe) begin
         // bytes past the third are acknowledged but ignored
         if (widx_r != BYTE_DONE) begin
            widx_nxt = widx_r + 2'h1;
         end
         if (widx_r == BYTE_SUB) begin
            sub_nxt = rx_data;
            if (ws_w[3]) begin
               chan_nxt = ws_w[2:0];
            end
         end else if (widx_r == BYTE_HI) begin
            hi_nxt = rx_data;
            if (sub_r == SUB_GAIN) begin
               gain_nxt = rx_data[GAIN_W-1:0];
            end
         end else if (widx_r == BYTE_LO && wo_w[3]) begin
            // undefined sub-addresses fall through untouched
            offset_nxt[wo_w[2:0]] = {hi_r[OFF_HI_W-1:0], rx_data};
         end
      end else if (tx_req && ridx_r != BYTE_DONE) begin
         ridx_nxt = ridx_r + 2'h1;
      end
      code_nxt = offset_nxt[chan_nxt];
   end

   always_comb begin
      tx_data = 8'h00;
      if (wo_w[3]) begin
         if (ridx_r == BYTE_SUB) begin
            tx_data = 8'(offset_r[wo_w[2:0]][SIGN_BIT:HI_LSB]);
         end else if (ridx_r == BYTE_HI) begin
            tx_data = offset_r[wo_w[2:0]][HI_LSB-1:0];
         end
      end else if (sub_r == SUB_GAIN && ridx_r == BYTE_SUB) begin
         tx_data = 8'(gain_r);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         chan_r <= CHAN_RESET;
         gain_r <= GAIN_RESET;
         code_r <= OFFSET_RESET;
         sub_r <= 8'h00;
         hi_r <= 8'h00;
         widx_r <= BYTE_SUB;
         ridx_r <= BYTE_SUB;
         for (int i = 0; i < NUM_CH; i++) begin
            offset_r[i] <= OFFSET_RESET;
         end
      end else begin
         chan_r <= chan_nxt;
         gain_r <= gain_nxt;
         code_r <= code_nxt;
         sub_r <= sub_nxt;
         hi_r <= hi_nxt;
         widx_r <= widx_nxt;
         ridx_r <= ridx_nxt;
         for (int i = 0; i < NUM_CH; i++) begin
            offset_r[i] <= offset_nxt[i];
         end
      end
   end

   // open-drain: only ever pulls low
   assign sda_out = 1'b0;
   assign chan_sel = chan_r;
   assign offset_sign = code_r[SIGN_BIT];
   assign offset_mag = code_r[MAG_W-1:0];
   assign gain_code = gain_r;

   sequence s_sub(logic [7:0] a);
      rx_strobe && widx_r == BYTE_SUB && rx_data == a;
   endsequence
   sequence s_off_write;
      rx_strobe && widx_r == BYTE_LO && wo_w[3];
   endsequence

   property p_sel_12;
      @(posedge clk) disable iff (rst)
      (s_sub(SUB_SEL1) |=> chan_sel == CH1) and (s_sub(SUB_SEL2) |=> chan_sel == CH2);
   endproperty
   a_sel_12: assert property (p_sel_12) else $error("select 1/2 wrong");
   property p_sel_34;
      @(posedge clk) disable iff (rst)
      (s_sub(SUB_SEL3) |=> chan_sel == CH3) and (s_sub(SUB_SEL4) |=> chan_sel == CH4);
   endproperty
   a_sel_34: assert property (p_sel_34) else $error("select 3/4 wrong");
   property p_sel_56;
      @(posedge clk) disable iff (rst)
      (s_sub(SUB_SEL5) |=> chan_sel == CH5) and (s_sub(SUB_SEL6) |=> chan_sel == CH6);
   endproperty
   a_sel_56: assert property (p_sel_56) else $error("select 5/6 wrong");
   property p_sel_78;
      @(posedge clk) disable iff (rst)
      (s_sub(SUB_SEL7) |=> chan_sel == CH7) and (s_sub(SUB_SEL8) |=> chan_sel == CH8);
   endproperty
   a_sel_78: assert property (p_sel_78) else $error("select 7/8 wrong");
   property p_chan_hold;
      @(posedge clk) disable iff (rst)
      $changed(chan_sel) |-> $past(rx_strobe && widx_r == BYTE_SUB && ws_w[3]);
   endproperty
   a_chan_hold: assert property (p_chan_hold) else $error("channel moved");
   property p_active;
      @(posedge clk) disable iff (rst)
      {offset_sign, offset_mag} == offset_r[chan_sel];
   endproperty
   a_active: assert property (p_active) else $error("wrong active word");
   property p_off_write;
      @(posedge clk) disable iff (rst)
      s_off_write
         |=> offset_r[$past(wo_w[2:0])] == {$past(hi_r[OFF_HI_W-1:0]), $past(rx_data)};
   endproperty
   a_off_write: assert property (p_off_write) else $error("offset write lost");
   property p_sign;
      @(posedge clk) disable iff (rst)
      (s_off_write and (wo_w[2:0] == chan_r)) |=> offset_sign == $past(hi_r[OFF_HI_W-1]);
   endproperty
   a_sign: assert property (p_sign) else $error("polarity wrong");
   property p_gain;
      @(posedge clk) disable iff (rst)
      rx_strobe && widx_r == BYTE_HI && sub_r == SUB_GAIN
         |=> gain_code == $past(rx_data[GAIN_W-1:0]);
   endproperty
   a_gain: assert property (p_gain) else $error("gain write lost");
   property p_unmapped;
      @(posedge clk) disable iff (rst)
      rx_strobe && widx_r != BYTE_SUB && !wo_w[3] && sub_r != SUB_GAIN
         |=> $stable(gain_code) && $stable(code_r);
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("undefined access took effect");
   property p_readback;
      @(posedge clk) disable iff (rst)
      // the high byte always starts with a zero bit, so the pin must pull low next
      tx_req && wo_w[3] && ridx_r == BYTE_SUB
         |-> (tx_data == 8'(offset_r[wo_w[2:0]][SIGN_BIT:HI_LSB])) ##1 sda_oe;
   endproperty
   a_readback: assert property (p_readback) else $error("readback high byte wrong");
endmodule

// ==== afe_pkg.sv ====
// Notes on behaviour
// - zero-byte command at 0x14 selects input pair 3, at 0x15 pair 4.
// - zero-byte command at 0x18 selects input pair 5, at 0x1a pair 6.
// - zero-byte command at 0x1c selects input pair 7, at 0x1e pair 8.
// - zero-byte command at 0x10 selects input pair 1, at 0x12 pair 2.
// - after reset input pair 1 is selected until another select command.
// - eight offset words kept; only the selected channel's word drives the converter.
// - offset bit 10 is polarity: zero positive, one negative.
// - offset bits 9:0 are the unsigned magnitude, forwarded with the polarity.
// - 0x3ff is +560mV, 0x7ff is -560mV, 0x000 and 0x400 give zero.
// - gain code is three bits; codes 0..7 give gains 2 to 760.
// - accesses to undefined sub-addresses change no state.
package afe_pkg;
   localparam logic [6:0] BUS_ADDR_DEFAULT = 7'h67;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   // sub-addresses of select commands
   localparam logic [7:0] SUB_SEL1 = 8'h10;
   localparam logic [7:0] SUB_SEL2 = 8'h12;
   localparam logic [7:0] SUB_SEL3 = 8'h14;
   localparam logic [7:0] SUB_SEL4 = 8'h15;
   localparam logic [7:0] SUB_SEL5 = 8'h18;
   localparam logic [7:0] SUB_SEL6 = 8'h1a;
   localparam logic [7:0] SUB_SEL7 = 8'h1c;
   localparam logic [7:0] SUB_SEL8 = 8'h1e;
   // register sub-addresses
   localparam logic [7:0] SUB_GAIN = 8'h06;
   localparam logic [7:0] OFFSET_WORD_CH1 = 8'h20;
   localparam logic [7:0] OFFSET_WORD_CH2 = 8'h22;
   localparam logic [7:0] OFFSET_WORD_CH3 = 8'h24;
   localparam logic [7:0] OFFSET_WORD_CH4 = 8'h25;
   localparam logic [7:0] OFFSET_WORD_CH5 = 8'h28;
   localparam logic [7:0] OFFSET_WORD_CH6 = 8'h2a;
   localparam logic [7:0] OFFSET_WORD_CH7 = 8'h2c;
   localparam logic [7:0] OFFSET_WORD_CH8 = 8'h2e;
   // channel indices (input pair n is code n-1)
   localparam logic [2:0] CH1 = 3'h0;
   localparam logic [2:0] CH2 = 3'h1;
   localparam logic [2:0] CH3 = 3'h2;
   localparam logic [2:0] CH4 = 3'h3;
   localparam logic [2:0] CH5 = 3'h4;
   localparam logic [2:0] CH6 = 3'h5;
   localparam logic [2:0] CH7 = 3'h6;
   localparam logic [2:0] CH8 = 3'h7;
   localparam int NUM_CH = 8;
   // field layout
   localparam int OFF_W = 11;
   localparam int SIGN_BIT = 10;
   localparam int MAG_W = 10;
   localparam int HI_LSB = 8;
   localparam int OFF_HI_W = 3;
   localparam int GAIN_W = 3;
   // reset values
   localparam logic [2:0] CHAN_RESET = CH1;
   localparam logic [2:0] GAIN_RESET = 3'h0;
   localparam logic [10:0] OFFSET_RESET = 11'h000;
   // position of a byte within a frame
   localparam logic [1:0] BYTE_SUB = 2'h0;
   localparam logic [1:0] BYTE_HI = 2'h1;
   localparam logic [1:0] BYTE_LO = 2'h2;
   localparam logic [1:0] BYTE_DONE = 2'h3;
endpackage

// ==== serial_byte_slave.sv ====
`timescale 1ns/100ps
module serial_byte_slave
   import afe_pkg::*;
#(
   parameter logic [6:0] BUS_ADDR = BUS_ADDR_DEFAULT
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_oe,
   output logic frame_start,
   output logic frame_stop,
   output logic rx_strobe,
   output logic [7:0] rx_data,
   output logic tx_req,
   input wire logic [7:0] tx_data
);
   typedef enum logic [2:0] {s_idle, s_addr, s_ack, s_rx, s_tx, s_mack} bus_state_t;
   bus_state_t state_r, state_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic [7:0] sh_r, sh_nxt;
   logic oe_r, oe_nxt, rw_r, rw_nxt, strobe_r, strobe_nxt;
   logic scl_q_r, sda_q_r;
   logic rise, fall;

   assign rise = scl & ~scl_q_r;
   assign fall = ~scl & scl_q_r;
   assign frame_start = scl & scl_q_r & sda_q_r & ~sda_in;
   assign frame_stop = scl & scl_q_r & ~sda_q_r & sda_in;

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      sh_nxt = sh_r;
      oe_nxt = oe_r;
      rw_nxt = rw_r;
      strobe_nxt = 1'b0;
      tx_req = 1'b0;
      if (frame_start) begin
         state_nxt = s_addr;
         cnt_nxt = '0;
         oe_nxt = 1'b0;
      end else if (frame_stop) begin
         state_nxt = s_idle;
         oe_nxt = 1'b0;
      end else begin
         unique case (state_r)
            s_idle: begin
            end
            s_addr, s_rx: begin
               if (rise && cnt_r != BYTE_BITS) begin
                  sh_nxt = {sh_r[6:0], sda_in};
                  cnt_nxt = cnt_r + 4'h1;
               end else if (fall && cnt_r == BYTE_BITS) begin
                  if (state_r == s_rx) begin
                     strobe_nxt = 1'b1;
                     oe_nxt = 1'b1;
                     state_nxt = s_ack;
                  end else if (sh_r[7:1] == BUS_ADDR) begin
                     rw_nxt = sh_r[0];
                     oe_nxt = 1'b1;
                     state_nxt = s_ack;
                  end else begin
                     state_nxt = s_idle;
                  end
               end
            end
            s_ack: begin
               if (fall) begin
                  if (rw_r) begin
                     tx_req = 1'b1;
                     sh_nxt = tx_data;
                     oe_nxt = ~tx_data[7];
                     cnt_nxt = 4'h1;
                     state_nxt = s_tx;
                  end else begin
                     oe_nxt = 1'b0;
                     cnt_nxt = '0;
                     state_nxt = s_rx;
                  end
               end
            end
            s_tx: begin
               if (fall) begin
                  if (cnt_r == BYTE_BITS) begin
                     oe_nxt = 1'b0;
                     state_nxt = s_mack;
                  end else begin
                     sh_nxt = {sh_r[6:0], 1'b0};
                     oe_nxt = ~sh_r[6];
                     cnt_nxt = cnt_r + 4'h1;
                  end
               end
            end
            s_mack: begin
               // a master nack ends the read burst
               if (rise) begin
                  state_nxt = sda_in ? s_idle : s_ack;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= s_idle;
         cnt_r <= '0;
         sh_r <= '0;
         oe_r <= 1'b0;
         rw_r <= 1'b0;
         strobe_r <= 1'b0;
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         sh_r <= sh_nxt;
         oe_r <= oe_nxt;
         rw_r <= rw_nxt;
         strobe_r <= strobe_nxt;
         scl_q_r <= scl;
         sda_q_r <= sda_in;
      end
   end

   assign sda_oe = oe_r;
   assign rx_strobe = strobe_r;
   assign rx_data = sh_r;
endmodule

// ==== bus_master.sv ====
`timescale 1ns/100ps
module bus_master
   import afe_pkg::*;
(
   input wire logic clk,
   output logic scl,
   output logic sda_in,
   input wire logic sda_oe,
   input wire logic sda_out
);
   logic sda_drv;
   // open-drain wire with pull-up: a released line reads high
   assign sda_in = sda_drv & (sda_oe ? sda_out : 1'b1);
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   task automatic half();
      repeat (4) @(posedge clk);
   endtask
   task automatic bit_x(input logic b, output logic r);
      half();
      sda_drv <= b;
      half();
      scl <= 1'b1;
      half();
      r = sda_in;
      scl <= 1'b0;
   endtask
   task automatic byte_x(input logic [7:0] d, input logic mack, output logic [7:0] q,
         output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], q[i]);
      end
      bit_x(mack, r);
      ack = ~r;
   endtask
   // also serves as a repeated start: sda released while scl is low
   task automatic start_c();
      half();
      sda_drv <= 1'b1;
      half();
      scl <= 1'b1;
      half();
      sda_drv <= 1'b0;
      half();
      scl <= 1'b0;
   endtask
   task automatic stop_c();
      half();
      sda_drv <= 1'b0;
      half();
      scl <= 1'b1;
      half();
      sda_drv <= 1'b1;
      half();
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] sub, input int n,
         input logic [15:0] d, output logic [15:0] acks);
      logic [7:0] q;
      logic k;
      start_c();
      byte_x({a, 1'b0}, 1'b1, q, k);
      acks = {15'h0, k};
      byte_x(sub, 1'b1, q, k);
      acks = acks + {15'h0, k};
      for (int i = 0; i < n; i++) begin
         byte_x((i == 0) ? d[15:8] : d[7:0], 1'b1, q, k);
         acks = acks + {15'h0, k};
      end
      stop_c();
   endtask
   task automatic rd(input logic [6:0] a, output logic [15:0] d);
      logic [7:0] q;
      logic k;
      start_c();
      byte_x({a, 1'b1}, 1'b1, q, k);
      byte_x(8'hff, 1'b0, d[15:8], k);
      byte_x(8'hff, 1'b1, d[7:0], k);
      stop_c();
   endtask
endmodule

// ==== testbench.sv ====
`timescale 1ns/100ps
module testbench
   import afe_pkg::*;
;
   logic clk, rst, scl, sda_in, sda_out, sda_oe, offset_sign;
   logic [2:0] chan_sel, gain_code, exp_ch, exp_gain;
   logic [9:0] offset_mag;
   logic [10:0] exp_off [8];
   logic [15:0] d, q, acks;
   int bad_count = 0, total_checks = 0, seed = 8, cycles = 0;
   logic [7:0] sel_sub [8] = '{SUB_SEL1, SUB_SEL2, SUB_SEL3, SUB_SEL4,
      SUB_SEL5, SUB_SEL6, SUB_SEL7, SUB_SEL8};
   logic [7:0] off_sub [8] = '{OFFSET_WORD_CH1, OFFSET_WORD_CH2, OFFSET_WORD_CH3,
      OFFSET_WORD_CH4, OFFSET_WORD_CH5, OFFSET_WORD_CH6, OFFSET_WORD_CH7, OFFSET_WORD_CH8};
   logic [10:0] corner [4] = '{11'h3ff, 11'h7ff, 11'h400, 11'h000};
   logic [7:0] undef_sub [4] = '{8'h13, 8'h21, 8'h30, 8'hff};
   afe_channel_offset_gain_regs u_dut (.clk(clk), .rst(rst), .scl(scl), .sda_in(sda_in),
      .sda_out(sda_out), .sda_oe(sda_oe), .chan_sel(chan_sel), .offset_sign(offset_sign),
      .offset_mag(offset_mag), .gain_code(gain_code));
   bus_master u_master (.clk(clk), .scl(scl), .sda_in(sda_in), .sda_oe(sda_oe),
      .sda_out(sda_out));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 90000) begin
         bad_count++;
         end_sim();
      end
   end
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      total_checks++;
      if (s !== e) begin
         bad_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic outs();
      chk({13'h0, chan_sel}, {13'h0, exp_ch});
      chk({15'h0, offset_sign}, {15'h0, exp_off[exp_ch][SIGN_BIT]});
      chk({6'h0, offset_mag}, {6'h0, exp_off[exp_ch][9:0]});
      chk({13'h0, gain_code}, {13'h0, exp_gain});
   endtask
   task automatic do_reset(int n);
      rst <= 1'b1;
      repeat (n) @(posedge clk);
      rst <= 1'b0;
      exp_ch = CHAN_RESET;
      exp_gain = GAIN_RESET;
      foreach (exp_off[i]) exp_off[i] = OFFSET_RESET;
      @(posedge clk);
   endtask
   // two-byte readback: upper five bits zero, then the stored eleven bits
   function automatic logic [15:0] rd_exp(input logic [10:0] w);
      rd_exp = {5'h0, w};
   endfunction
   task automatic rd_off(int c);
      u_master.wr(BUS_ADDR_DEFAULT, off_sub[c], 0, 16'h0, acks);
      u_master.rd(BUS_ADDR_DEFAULT, q);
      chk(q, rd_exp(exp_off[c]));
   endtask
   initial begin
      rst = 1'b1;
      do_reset(20);
      outs();
      for (int c = 0; c < NUM_CH; c++) rd_off(c);
      // random words, the table's corner codes on the first four channels
      for (int c = 0; c < NUM_CH; c++) begin
         d = 16'($random(seed));
         if (c < 4) d[10:0] = corner[c];
         u_master.wr(BUS_ADDR_DEFAULT, off_sub[c], 2, d, acks);
         chk(acks, 16'h4);
         exp_off[c] = d[10:0];
         // a lone high byte must leave the word alone
         u_master.wr(BUS_ADDR_DEFAULT, off_sub[c], 1, ~d, acks);
      end
      for (int c = NUM_CH - 1; c >= 0; c--) begin
         u_master.wr(BUS_ADDR_DEFAULT, sel_sub[c], 0, 16'h0, acks);
         chk(acks, 16'h2);
         exp_ch = 3'(c);
         outs();
         rd_off(c);
      end
      for (int g = 0; g < 8; g++) begin
         d = 16'($random(seed));
         d[10:8] = 3'(g);
         u_master.wr(BUS_ADDR_DEFAULT, SUB_GAIN, 1, d, acks);
         exp_gain = 3'(g);
         outs();
         u_master.rd(BUS_ADDR_DEFAULT, q);
         chk(q, rd_exp({exp_gain, 8'h00}));
      end
      for (int k = 0; k < 4; k++) begin
         u_master.wr(BUS_ADDR_DEFAULT, undef_sub[k], 2, 16'($random(seed)), acks);
         chk(acks, 16'h4);
         outs();
      end
      for (int c = 0; c < NUM_CH; c++) rd_off(c);
      u_master.wr(BUS_ADDR_DEFAULT ^ 7'h01, SUB_SEL5, 0, 16'h0, acks);
      chk(acks, 16'h0);
      outs();
      do_reset(2);
      outs();
      rd_off(3);
      end_sim();
   end
endmodule
